// ---- logic/spcr_top.sv ----
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] after reset load eeprom bytes 8-19 in order
// [R2] software rewrites registers by application-0 index
// [R3] no eeprom: defaults 01, 85/84, 24
// [R4] port n bytes at 8 plus 3(n-1)
// [R5] three registers form one 24-bit word
// [R6] bit0 set: shutdown asserted during usb suspend
// [R7] bits 3:2: 00 input, 10 output
// [R8] bits 5:4 select rts drive method
// [R9] bit6 selects wired or infrared mode
// [R10] reserved bits 1,7 read zero, writes ignored
module spcr_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ee_present_i,
   input  wire logic        ee_ack_i,
   input  wire logic [7:0]  ee_data_i,
   output logic             ee_req_o,
   output logic      [7:0]  ee_addr_o,
   output logic             load_done_o,
   input  wire logic        usb_suspend_i,
   input  wire logic [3:0]  mcr_rts_i,
   input  wire logic [3:0]  tx_empty_i,
   output logic      [3:0]  shutdown_o,
   output logic      [3:0]  aux_out_en_o,
   output logic      [3:0]  rts_o,
   output logic      [3:0]  irda_mode_o,
   output logic      [95:0] cfg_word_o
);
   localparam int NR = spcr_pkg::NUM_REGS;
   localparam int NP = spcr_pkg::NUM_PORTS;
   localparam int RP = spcr_pkg::REGS_PER_PORT;

   // bit 4 flags a hit, bits 3:0 give the slot
   function automatic logic [4:0] slot_of(input logic [4:0] idx);
      logic [4:0] r;
      r = 5'h00;
      for (int k = 0; k < NR; k++) begin
         if (idx == spcr_pkg::REG_IDX[k]) begin
            r = {1'b1, 4'(k)};
         end
      end
      return r;
   endfunction : slot_of

   function automatic logic [7:0] wr_mask(input logic [3:0] s);
      logic [7:0] m;
      m = 8'hFF;
      if (int'(s) % RP == 0) begin
         m = spcr_pkg::LOW_RSVD_MASK;
      end
      return m;
   endfunction : wr_mask

   // eeprom loader
   typedef enum {LD_PROBE, LD_FETCH, LD_DONE} spcr_ld_t;
   spcr_ld_t   ld_q, ld_d;
   logic       req_q, req_d;
   logic [7:0] addr_q, addr_d;
   logic       found_q, found_d;
   logic       done_q, done_d;
   logic [3:0] ld_slot;
   logic       ld_store;

   assign ld_slot  = 4'(addr_q - spcr_pkg::EE_CFG_FIRST);
   assign ld_store = req_q & ee_ack_i;

   always_comb begin
      ld_d    = ld_q;
      req_d   = req_q;
      addr_d  = addr_q;
      found_d = found_q;
      unique case (ld_q)
         LD_PROBE: begin
            // absent eeprom keeps the built-in values
            if (ee_present_i) begin
               found_d = 1'b1;
               req_d   = 1'b1;
               addr_d  = spcr_pkg::EE_CFG_FIRST; // [R1] [R4]
               ld_d    = LD_FETCH;
            end else begin
               ld_d = LD_DONE; // [R3]
            end
         end
         LD_FETCH: begin
            if (ee_ack_i) begin
               if (addr_q == spcr_pkg::EE_CFG_LAST) begin
                  req_d = 1'b0;
                  ld_d  = LD_DONE;
               end else begin
                  addr_d = addr_q + 8'h01; // [R1] [R4]
               end
            end
         end
         LD_DONE: begin
            req_d = 1'b0;
         end
      endcase
      // registered so the done pin comes straight from a flop
      done_d = (ld_d == LD_DONE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ld_q    <= LD_PROBE;
         req_q   <= 1'b0;
         addr_q  <= spcr_pkg::EE_CFG_FIRST;
         found_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (ce_i) begin
         ld_q    <= ld_d;
         req_q   <= req_d;
         addr_q  <= addr_d;
         found_q <= found_d;
         done_q  <= done_d;
      end
   end

   // wishbone slave: ack one cycle after the strobe
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [4:0]  hit_slot;
   logic        hit, stat_hit, wr_en;
   logic [7:0]  cfg_q [NR];
   logic [7:0]  cfg_d [NR];

   assign hit_slot = slot_of(wb_adr_i[6:2]);
   assign hit      = hit_slot[4] & ~wb_adr_i[7];
   assign stat_hit = (wb_adr_i[6:2] == spcr_pkg::IDX_STATUS)
                     & ~wb_adr_i[7];
   // write commits at the edge that sees ack high
   assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q
                     & wb_sel_i[0] & hit;

   always_comb begin
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d = 32'h0000_0000;
      if (ack_d & ~wb_we_i) begin
         if (hit) begin
            dat_d[7:0] = cfg_q[hit_slot[3:0]]; // [R2]
         end else if (stat_hit) begin
            dat_d[spcr_pkg::STAT_DONE]  = (ld_q == LD_DONE);
            dat_d[spcr_pkg::STAT_FOUND] = found_q;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // configuration store; a bus write beats a load to the same slot
   always_comb begin
      for (int k = 0; k < NR; k++) begin
         cfg_d[k] = cfg_q[k];
      end
      if (ld_store) begin
         cfg_d[ld_slot] = ee_data_i & wr_mask(ld_slot); // [R1] [R10]
      end
      if (wr_en) begin
         cfg_d[hit_slot[3:0]] = wb_dat_i[7:0]
                                & wr_mask(hit_slot[3:0]); // [R2] [R10]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < NR; k++) begin
            cfg_q[k] <= spcr_pkg::REG_RST[k]; // [R3]
         end
      end else if (ce_i) begin
         for (int k = 0; k < NR; k++) begin
            cfg_q[k] <= cfg_d[k];
         end
      end
   end

   // per-port controls, registered to keep outputs glitch free
   logic [3:0] shdn_q, shdn_d, aux_q, aux_d;
   logic [3:0] rts_q, rts_d, irda_q, irda_d;

   always_comb begin
      logic [7:0] low;
      low = 8'h00;
      for (int p = 0; p < NP; p++) begin
         low       = cfg_q[p * RP];
         shdn_d[p] = low[spcr_pkg::SHDN_BIT] & usb_suspend_i; // [R6]
         aux_d[p]  = (low[spcr_pkg::AUX_LSB +: 2]
                      == spcr_pkg::AUX_OUTPUT); // [R7]
         irda_d[p] = low[spcr_pkg::IRDA_BIT]; // [R9]
         unique case (spcr_pkg::spcr_rts_t'(low[spcr_pkg::RTS_LSB +: 2]))
            spcr_pkg::RTS_MCR_LOW:       rts_d[p] = ~mcr_rts_i[p]; // [R8]
            spcr_pkg::RTS_MCR_HIGH:      rts_d[p] = mcr_rts_i[p];
            spcr_pkg::RTS_DATA_ACTIVE:   rts_d[p] = ~tx_empty_i[p];
            spcr_pkg::RTS_DATA_INACTIVE: rts_d[p] = tx_empty_i[p];
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shdn_q <= 4'h0;
         aux_q  <= 4'h0;
         rts_q  <= spcr_pkg::RTS_RST;
         irda_q <= 4'h0;
      end else if (ce_i) begin
         shdn_q <= shdn_d;
         aux_q  <= aux_d;
         rts_q  <= rts_d;
         irda_q <= irda_d;
      end
   end

   // one 24-bit word per port, low register in the low byte
   for (genvar p = 0; p < NP; p++) begin : g_word
      assign cfg_word_o[p*24 +: 24] = {cfg_q[p*RP+2],
                                       cfg_q[p*RP+1],
                                       cfg_q[p*RP]}; // [R5]
   end

   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = dat_q;
   assign ee_req_o     = req_q;
   assign ee_addr_o    = addr_q;
   assign load_done_o  = done_q;
   assign shutdown_o   = shdn_q;
   assign aux_out_en_o = aux_q;
   assign rts_o        = rts_q;
   assign irda_mode_o  = irda_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_default_values: assert property ( // [R3]
      $fell(rst_i) |-> cfg_q[0] == 8'h01 && cfg_q[1] == 8'h85
                    && cfg_q[2] == 8'h24 && cfg_q[4] == 8'h84)
      else $error("reset defaults wrong");

   chk_load_first_byte: assert property ( // [R1]
      (ce_i && ee_req_o && ee_ack_i && ee_addr_o == 8'h08 && !wr_en)
      |=> cfg_q[0] == ($past(ee_data_i) & 8'h7D))
      else $error("first eeprom byte not loaded");

   chk_load_addr_step: assert property ( // [R4]
      (ce_i && ee_req_o && ee_ack_i && ee_addr_o != 8'h13)
      |=> ee_req_o && ee_addr_o == $past(ee_addr_o) + 8'h01)
      else $error("eeprom address did not step by one");

   chk_load_range: assert property ( // [R1]
      ee_req_o |-> ee_addr_o >= 8'h08 && ee_addr_o <= 8'h13)
      else $error("eeprom address out of range");

   chk_bus_write_mid: assert property ( // [R2]
      (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
       && wb_sel_i[0] && wb_adr_i == 8'h14)
      |=> cfg_q[1] == $past(wb_dat_i[7:0]))
      else $error("index 5 write lost");

   chk_ack_single: assert property (
      (ce_i && wb_ack_o) |=> !wb_ack_o)
      else $error("ack held two cycles");

   chk_word_layout: assert property ( // [R5]
      cfg_word_o[47:24] == {cfg_q[5], cfg_q[4], cfg_q[3]})
      else $error("port word misassembled");

   chk_reserved_zero: assert property ( // [R10]
      cfg_q[0][1] == 1'b0 && cfg_q[0][7] == 1'b0
      && cfg_q[9][1] == 1'b0 && cfg_q[9][7] == 1'b0)
      else $error("reserved bit set");

   chk_shutdown_suspend: assert property ( // [R6]
      (ce_i && usb_suspend_i && cfg_q[0][0]) |=> shutdown_o[0])
      else $error("shutdown not asserted in suspend");

   chk_keep_powered: assert property ( // [R6]
      (ce_i && !cfg_q[3][0]) |=> !shutdown_o[1])
      else $error("shutdown asserted while disabled");

   chk_aux_output: assert property ( // [R7]
      (ce_i && cfg_q[0][3:2] == 2'h0) |=> !aux_out_en_o[0])
      else $error("aux pin not input");

   chk_rts_data: assert property ( // [R8]
      (ce_i && cfg_q[0][5:4] == 2'h2) |=> rts_o[0] == !$past(tx_empty_i[0]))
      else $error("rts not following buffer state");

   chk_rts_mcr_low: assert property ( // [R8]
      (ce_i && cfg_q[6][5:4] == 2'h0) |=> rts_o[2] == !$past(mcr_rts_i[2]))
      else $error("rts active low method wrong");

   chk_irda_mode: assert property ( // [R9]
      ce_i |=> irda_mode_o[3] == $past(cfg_q[9][6]))
      else $error("irda mode not following bit 6");

   cov_load_done: cover property (ee_req_o ##1 load_done_o && !ee_req_o);
   cov_suspend_off: cover property (shutdown_o[0] ##1 !shutdown_o[0]);
   cov_bus_write: cover property (wr_en);
   cov_irda_on: cover property (!irda_mode_o[1] ##1 irda_mode_o[1]);
endmodule : spcr_top
`default_nettype wire

// ---- include/spcr_pkg.sv ----
package spcr_pkg;
   localparam int NUM_PORTS     = 4;
   localparam int REGS_PER_PORT = 3;
   localparam int NUM_REGS      = 12;
   // configuration block position in the serial eeprom
   localparam logic [7:0] EE_CFG_FIRST = 8'h08;
   localparam logic [7:0] EE_CFG_LAST  = 8'h13;
   // application 0 register indices, slot order
   localparam logic [4:0] REG_IDX [NUM_REGS] = '{
      5'h04, 5'h05, 5'h06,
      5'h16, 5'h17, 5'h18,
      5'h19, 5'h1A, 5'h1B,
      5'h1C, 5'h1D, 5'h1E};
   localparam logic [7:0] REG_RST [NUM_REGS] = '{
      8'h01, 8'h85, 8'h24,
      8'h01, 8'h84, 8'h24,
      8'h01, 8'h84, 8'h24,
      8'h01, 8'h84, 8'h24};
   // load status register, read only
   localparam logic [4:0] IDX_STATUS  = 5'h00;
   localparam int         STAT_DONE   = 0;
   localparam int         STAT_FOUND  = 1;
   // low register fields
   localparam logic [7:0] LOW_RSVD_MASK = 8'h7D;
   localparam int         SHDN_BIT      = 0;
   localparam int         AUX_LSB       = 2;
   localparam logic [1:0] AUX_OUTPUT    = 2'h2;
   localparam int         RTS_LSB       = 4;
   localparam int         IRDA_BIT      = 6;
   localparam logic [3:0] RTS_RST       = 4'hF;
   typedef enum logic [1:0] {
      RTS_MCR_LOW,
      RTS_MCR_HIGH,
      RTS_DATA_ACTIVE,
      RTS_DATA_INACTIVE
   } spcr_rts_t;
endpackage : spcr_pkg

// ---- testbench/spcr_ee_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spcr_ee_model #(
   parameter int WAIT = 3
) (
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic [7:0] addr_i,
   output logic            ack_o,
   output logic      [7:0] data_o
);
   int cnt;
   initial begin
      ack_o  = 1'b0;
      data_o = 8'h00;
      cnt    = 0;
   end
   // odd addresses answer slowly, even ones at once
   always @(posedge clk_i) begin
      ack_o  <= 1'b0;
      data_o <= ~data_o; // data is not held outside the ack cycle
      if (req_i && !ack_o) begin
         cnt <= cnt + 1;
         if (cnt >= (addr_i[0] ? WAIT : 0)) begin
            cnt    <= 0;
            ack_o  <= 1'b1;
            data_o <= {addr_i[3:0], ~addr_i[3:0]};
         end
      end
   end
endmodule : spcr_ee_model
`default_nettype wire

// ---- testbench/spcr_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module spcr_top_tb;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
   logic        ce = 1'b1, eep = 1'b0, susp = 1'b0, ack, ee_ack, ee_req;
   logic        done;
   logic [7:0]  adr = 8'h00, ee_dat, ee_adr;
   logic [3:0]  sel = 4'h0, mcr = 4'h5, txe = 4'h3, shdn, aux, rts, irda;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [95:0] cfg;
   int          bad_count = 0, n_tests = 0;

   spcr_top i_spcr_top (.clk_i(clk), .rst_i(rst), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ee_present_i(eep), .ee_ack_i(ee_ack), .ee_data_i(ee_dat),
      .ee_req_o(ee_req), .ee_addr_o(ee_adr), .load_done_o(done),
      .usb_suspend_i(susp), .mcr_rts_i(mcr), .tx_empty_i(txe),
      .shutdown_o(shdn), .aux_out_en_o(aux), .rts_o(rts),
      .irda_mode_o(irda), .cfg_word_o(cfg));
   spcr_ee_model i_spcr_ee_model (.clk_i(clk), .req_i(ee_req),
      .addr_i(ee_adr), .ack_o(ee_ack), .data_o(ee_dat));

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // master holds the request until ack is seen at a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] s);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h0, d};
      // no timeout here; if ack never comes only the watchdog ends this wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic chk_load(input logic p);
      logic [7:0]  e, a;
      logic [95:0] ce;
      eep <= p;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      while (done !== 1'b1) begin
         @(posedge clk);
      end
      `CHK(ee_req, 1'b0)
      `CHK(ee_adr, p ? spcr_pkg::EE_CFG_LAST : spcr_pkg::EE_CFG_FIRST)
      for (int k = 0; k < 12; k++) begin
         a = 8'h08 + 8'(k);
         e = p ? {a[3:0], ~a[3:0]} : spcr_pkg::REG_RST[k];
         if (k % 3 == 0) e = e & 8'h7D;
         ce[8*k +: 8] = e;
         bus(1'b0, {1'b0, spcr_pkg::REG_IDX[k], 2'b00}, 8'h00, 4'h1);
         `CHK(q, {24'h0, e})
      end
      `CHK(cfg, ce)
      bus(1'b0, 8'h00, 8'h00, 4'h1);
      `CHK(q, {30'h0, p, 1'b1})
   endtask : chk_load

   task automatic chk_write();
      bus(1'b1, 8'h10, 8'hFF, 4'h1);
      bus(1'b0, 8'h10, 8'h00, 4'h1);
      `CHK(q, 32'h7D)
      // aux code 11 must stay an input
      @(negedge clk);
      `CHK(aux[0], 1'b0)
      `CHK(irda[0], 1'b1)
      @(posedge clk);
      bus(1'b1, 8'h74, 8'h5A, 4'h0);
      bus(1'b0, 8'h74, 8'h00, 4'h1);
      `CHK(q, 32'h84)
      bus(1'b1, 8'h74, 8'h3C, 4'h1);
      bus(1'b0, 8'h74, 8'h00, 4'h1);
      `CHK(q, 32'h3C)
      bus(1'b1, 8'h14, 8'hA5, 4'h1);
      bus(1'b0, 8'h14, 8'h00, 4'h1);
      `CHK(q, 32'hA5)
      bus(1'b1, 8'h80, 8'h77, 4'h1);
      bus(1'b0, 8'h80, 8'h00, 4'h1);
      `CHK(q, 32'h0)
   endtask : chk_write

   task automatic chk_ports();
      logic [1:0] m;
      logic [3:0] r;
      susp <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         for (int p = 0; p < 4; p++) begin
            bus(1'b1, {1'b0, spcr_pkg::REG_IDX[3*p], 2'b00},
                {1'b0, m[0], m, m[1], 2'b00, m[0]}, 4'h1);
         end
         r = (m == 2'd0) ? ~mcr : (m == 2'd1) ? mcr :
             (m == 2'd2) ? ~txe : txe;
         repeat (2) @(posedge clk);
         @(negedge clk);
         `CHK(shdn, {4{m[0]}})
         `CHK(aux, {4{m[1]}})
         `CHK(rts, r)
         `CHK(irda, {4{m[0]}})
         @(posedge clk);
      end
      susp <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(shdn, 4'h0)
   endtask : chk_ports

   // clock enable low must hold the shutdown outputs where they stand
   task automatic chk_freeze();
      @(posedge clk);
      ce <= 1'b0;
      susp <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(shdn, 4'h0)
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(shdn, 4'hF)
      @(posedge clk);
      susp <= 1'b0;
   endtask : chk_freeze

   // a full pass needs well under two thousand cycles
   initial begin
      repeat (6000) @(posedge clk);
      bad_count++;
      complete_run();
   end

   initial begin
      chk_load(1'b0);
      chk_write();
      chk_load(1'b1);
      chk_ports();
      chk_freeze();
      complete_run();
   end
endmodule : spcr_top_tb
`default_nettype wire
